/* scan_pkg.sv */
// Shared constants and types for the boundary-scan test port
package scan_pkg;
    // ****************************************
    // Widths and chain layout
    // ****************************************
    localparam int IR_W = 4;
    localparam int ID_W = 32;
    localparam int IO_N = 4;
    localparam int BSR_LEN = 2 * IO_N + 1;
    localparam int BSR_OUT_LSB = IO_N;
    localparam int BSR_OE_BIT = 2 * IO_N;
    localparam int SNAP_W = 3 + IO_N + 1;
    // ****************************************
    // Identity word field positions
    // ****************************************
    localparam int REV_MSB = 31;
    localparam int REV_LSB = 28;
    localparam int PART_MSB = 27;
    localparam int PART_LSB = 12;
    localparam int MFR_MSB = 11;
    localparam int MFR_LSB = 1;
    localparam int ID_MARK_BIT = 0;
    localparam logic ID_MARK = 1'h1;
    // ****************************************
    // Instruction codes
    // ****************************************
    localparam logic [3:0] drive_cells_instr = 4'h0;
    localparam logic [3:0] sample_preload_instr = 4'h1;
    localparam logic [3:0] read_identity_instr = 4'h2;
    localparam logic [3:0] highz_instr = 4'h3;
    localparam logic [3:0] clamp_instr = 4'h8;
    localparam logic [3:0] capture_ir_pattern_instr = 4'hd;
    localparam logic [3:0] bypass_instr = 4'hf;
    localparam logic [1:0] IR_LOW_PATTERN = 2'h1;
    localparam logic [3:0] IR_RESET = read_identity_instr;
    localparam logic BYPASS_CAPTURE = 1'h0;
    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [15:0] {
        S_TLR = 16'h0001, S_RTI = 16'h0002, S_SEL_DR = 16'h0004, S_CAP_DR = 16'h0008,
        S_SHIFT_DR = 16'h0010, S_EXIT1_DR = 16'h0020, S_PAUSE_DR = 16'h0040,
        S_EXIT2_DR = 16'h0080, S_UPD_DR = 16'h0100, S_SEL_IR = 16'h0200,
        S_CAP_IR = 16'h0400, S_SHIFT_IR = 16'h0800, S_EXIT1_IR = 16'h1000,
        S_PAUSE_IR = 16'h2000, S_EXIT2_IR = 16'h4000, S_UPD_IR = 16'h8000
    } tap_state_t;
    typedef enum logic [2:0] {PATH_BYP = 3'h1, PATH_ID = 3'h2, PATH_BSR = 3'h4} path_t;
    typedef enum logic [2:0] {MODE_FUNC = 3'h1, MODE_DRIVE = 3'h2, MODE_HIGHZ = 3'h4} mode_t;
endpackage

/* tap_ctl_if.sv */
// Controller state carried from the TAP sequencer to the scan datapath
`timescale 1ns/1ps
`default_nettype none
interface tap_ctl_if;
    scan_pkg::tap_state_t state;
    modport ctrl (output state);
    modport user (input state);
endinterface
`default_nettype wire

/* tap_fsm.sv */
// Sixteen-state TAP sequencer, clocked by the test clock
`timescale 1ns/1ps
`default_nettype none
module tap_fsm (
    input wire logic tck,      // Test clock
    input wire logic tap_rst,  // Synchronised scan reset, high active
    input wire logic tms,      // Mode select, sampled on rising tck
    tap_ctl_if.ctrl ctl        // State out to the datapath
);
    scan_pkg::tap_state_t state_q, state_d;

    // Next state from mode select
    always_comb begin
        state_d = state_q;
        case (state_q)
            scan_pkg::S_TLR: state_d = tms ? scan_pkg::S_TLR : scan_pkg::S_RTI;
            scan_pkg::S_RTI: state_d = tms ? scan_pkg::S_SEL_DR : scan_pkg::S_RTI;
            scan_pkg::S_SEL_DR: state_d = tms ? scan_pkg::S_SEL_IR : scan_pkg::S_CAP_DR;
            scan_pkg::S_CAP_DR: state_d = tms ? scan_pkg::S_EXIT1_DR : scan_pkg::S_SHIFT_DR;
            scan_pkg::S_SHIFT_DR: state_d = tms ? scan_pkg::S_EXIT1_DR : scan_pkg::S_SHIFT_DR;
            scan_pkg::S_EXIT1_DR: state_d = tms ? scan_pkg::S_UPD_DR : scan_pkg::S_PAUSE_DR;
            scan_pkg::S_PAUSE_DR: state_d = tms ? scan_pkg::S_EXIT2_DR : scan_pkg::S_PAUSE_DR;
            scan_pkg::S_EXIT2_DR: state_d = tms ? scan_pkg::S_UPD_DR : scan_pkg::S_SHIFT_DR;
            scan_pkg::S_UPD_DR: state_d = tms ? scan_pkg::S_SEL_DR : scan_pkg::S_RTI;
            scan_pkg::S_SEL_IR: state_d = tms ? scan_pkg::S_TLR : scan_pkg::S_CAP_IR;
            scan_pkg::S_CAP_IR: state_d = tms ? scan_pkg::S_EXIT1_IR : scan_pkg::S_SHIFT_IR;
            scan_pkg::S_SHIFT_IR: state_d = tms ? scan_pkg::S_EXIT1_IR : scan_pkg::S_SHIFT_IR;
            scan_pkg::S_EXIT1_IR: state_d = tms ? scan_pkg::S_UPD_IR : scan_pkg::S_PAUSE_IR;
            scan_pkg::S_PAUSE_IR: state_d = tms ? scan_pkg::S_EXIT2_IR : scan_pkg::S_PAUSE_IR;
            scan_pkg::S_EXIT2_IR: state_d = tms ? scan_pkg::S_UPD_IR : scan_pkg::S_SHIFT_IR;
            scan_pkg::S_UPD_IR: state_d = tms ? scan_pkg::S_SEL_DR : scan_pkg::S_RTI;
            default: state_d = scan_pkg::S_TLR;
        endcase
    end

    // Power-up reset parks the sequencer without needing the test reset pin
    always_ff @(posedge tck) begin
        if (tap_rst) begin
            state_q <= scan_pkg::S_TLR;
        end else begin
            state_q <= state_d;
        end
    end

    assign ctl.state = state_q;

    reset_parks_tap_a: assert property (@(posedge tck) disable iff (tap_rst)
        $fell(tap_rst) |-> state_q == scan_pkg::S_TLR)
        else $error("sequencer not in reset state after reset");
endmodule
`default_nettype wire

/* scan_port_instruction_decode.sv */
// Boundary-scan port: instruction decode, scan paths and pad takeover
// Notes on behaviour
// - Identity bits 31:28 hold revision code
// - Bits 27:12 hold part code per organisation
// - Bits 11:1 hold the maker code
// - Identity bit 0 always reads one
// - Opcode 0000 drives cells, boundary chain path
// - Opcode 0001 samples pins into boundary chain
// - Opcode 0001 accepts preloaded cell values
// - Opcode 0010 loads and selects identity word
// - Opcode 0011 floats outputs, selects bypass bit
// - Opcode 1000 drives cells, selects bypass bit
// - Capture-instruction state loads code 1101
// - Captured instruction low bits are 01
// - Opcode 1111 shortens path to one bit
// - Scan logic resets itself at power-up
`timescale 1ns/1ps
`default_nettype none
module scan_port_instruction_decode #(
    parameter logic WIDE_ORG = 1'h1,               // Wide-word organisation strap
    parameter logic [3:0] REV_CODE = 4'h1,         // Arbitrary value
    parameter logic [15:0] PART_WIDE = 16'h0a51,   // Arbitrary value
    parameter logic [15:0] PART_NARROW = 16'h0a52, // Arbitrary value
    parameter logic [10:0] MFR_CODE = 11'h05a      // Arbitrary value
) (
    input wire logic core_clk,                          // Core clock, 10 MHz
    input wire logic rst_n,                             // Core reset, sync, low
    input wire logic tck,                               // Test clock
    input wire logic tms,                               // Test mode select
    input wire logic tdi,                               // Test data in
    input wire logic trst_n,                            // Optional test reset, low
    output logic tdo_out,                               // Test data out level
    output logic tdo_oe_n,                              // Low while driving test out
    input wire logic [scan_pkg::IO_N-1:0] func_out,     // Memory output data
    input wire logic func_oe_n,                         // Memory output enable, low
    input wire logic [scan_pkg::IO_N-1:0] pin_in,       // Device input pin levels
    output logic [scan_pkg::IO_N-1:0] pad_out,          // Output pad data
    output logic pad_oe_n                               // Output pad enable, low
);
    // ****************************************
    // Decode helpers
    // ****************************************
    // Reserved codes fall through to the one-bit path
    function automatic scan_pkg::path_t path_of(input logic [3:0] op);
        if (op == scan_pkg::drive_cells_instr || op == scan_pkg::sample_preload_instr) begin
            path_of = scan_pkg::PATH_BSR;
        end else if (op == scan_pkg::read_identity_instr) begin
            path_of = scan_pkg::PATH_ID;
        end else begin
            path_of = scan_pkg::PATH_BYP;
        end
    endfunction

    // Only three codes take the pads away from the memory
    function automatic scan_pkg::mode_t mode_of(input logic [3:0] op);
        if (op == scan_pkg::drive_cells_instr || op == scan_pkg::clamp_instr) begin
            mode_of = scan_pkg::MODE_DRIVE;
        end else if (op == scan_pkg::highz_instr) begin
            mode_of = scan_pkg::MODE_HIGHZ;
        end else begin
            mode_of = scan_pkg::MODE_FUNC;
        end
    endfunction

    // ****************************************
    // Test-clock domain: reset and pin sampling
    // ****************************************
    logic trst_s1_q, trst_s2_q, por_s1_q, por_s2_q;
    logic [scan_pkg::BSR_LEN-1:0] pin_s1_q, pin_s2_q;
    logic tap_rst;

    // Core reset doubles as power-up reset, so the test reset pin may idle
    always_ff @(posedge tck) begin
        trst_s1_q <= trst_n;
        trst_s2_q <= trst_s1_q;
        por_s1_q <= rst_n;
        por_s2_q <= por_s1_q;
        pin_s1_q <= {pad_oe_n, pad_out, pin_in};
        pin_s2_q <= pin_s1_q;
    end
    assign tap_rst = !trst_s2_q || !por_s2_q;

    tap_ctl_if ctl();
    tap_fsm u_tap (
        .tck(tck),
        .tap_rst(tap_rst),
        .tms(tms),
        .ctl(ctl.ctrl)
    );

    // ****************************************
    // Instruction and data registers
    // ****************************************
    localparam logic [15:0] PART_CODE = WIDE_ORG ? PART_WIDE : PART_NARROW;
    logic [scan_pkg::ID_W-1:0] id_word;
    logic [3:0] ir_q, ir_d, ir_shift_q, ir_shift_d;
    logic byp_q, byp_d;
    logic [scan_pkg::ID_W-1:0] id_q, id_d;
    logic [scan_pkg::BSR_LEN-1:0] bsr_q, bsr_d, upd_q, upd_d;
    scan_pkg::path_t path;

    assign id_word = {REV_CODE, PART_CODE, MFR_CODE, scan_pkg::ID_MARK};
    assign path = path_of(ir_q);

    // Capture, shift and update per controller state
    always_comb begin
        ir_d = ir_q;
        ir_shift_d = ir_shift_q;
        byp_d = byp_q;
        id_d = id_q;
        bsr_d = bsr_q;
        upd_d = upd_q;
        case (ctl.state)
            scan_pkg::S_TLR: ir_d = scan_pkg::IR_RESET;
            scan_pkg::S_CAP_IR: ir_shift_d = scan_pkg::capture_ir_pattern_instr;
            scan_pkg::S_SHIFT_IR: ir_shift_d = {tdi, ir_shift_q[3:1]};
            scan_pkg::S_UPD_IR: ir_d = ir_shift_q;
            scan_pkg::S_CAP_DR: begin
                if (path == scan_pkg::PATH_BSR) begin
                    bsr_d = pin_s2_q;
                end else if (path == scan_pkg::PATH_ID) begin
                    id_d = id_word;
                end else begin
                    byp_d = scan_pkg::BYPASS_CAPTURE;
                end
            end
            scan_pkg::S_SHIFT_DR: begin
                if (path == scan_pkg::PATH_BSR) begin
                    bsr_d = {tdi, bsr_q[scan_pkg::BSR_LEN-1:1]};
                end else if (path == scan_pkg::PATH_ID) begin
                    id_d = {tdi, id_q[scan_pkg::ID_W-1:1]};
                end else begin
                    byp_d = tdi;
                end
            end
            scan_pkg::S_UPD_DR: begin
                if (path == scan_pkg::PATH_BSR) begin
                    upd_d = bsr_q;
                end
            end
            default: ir_d = ir_q;
        endcase
    end

    always_ff @(posedge tck) begin
        if (tap_rst) begin
            ir_q <= scan_pkg::IR_RESET;
            ir_shift_q <= scan_pkg::capture_ir_pattern_instr;
            byp_q <= scan_pkg::BYPASS_CAPTURE;
            id_q <= '0;
            bsr_q <= '0;
            upd_q <= '0;
        end else begin
            ir_q <= ir_d;
            ir_shift_q <= ir_shift_d;
            byp_q <= byp_d;
            id_q <= id_d;
            bsr_q <= bsr_d;
            upd_q <= upd_d;
        end
    end

    // ****************************************
    // Test data out, on the falling edge
    // ****************************************
    logic tdo_q, tdo_d, tdo_oe_n_q, tdo_oe_n_d;

    // Falling-edge launch gives the controller a half period of hold
    always_comb begin
        tdo_d = tdo_q;
        tdo_oe_n_d = 1'h1;
        if (ctl.state == scan_pkg::S_SHIFT_IR) begin
            tdo_d = ir_shift_q[0];
            tdo_oe_n_d = 1'h0;
        end else if (ctl.state == scan_pkg::S_SHIFT_DR) begin
            tdo_oe_n_d = 1'h0;
            if (path == scan_pkg::PATH_BSR) begin
                tdo_d = bsr_q[0];
            end else if (path == scan_pkg::PATH_ID) begin
                tdo_d = id_q[0];
            end else begin
                tdo_d = byp_q;
            end
        end
    end

    always_ff @(negedge tck) begin
        if (tap_rst) begin
            tdo_q <= 1'h0;
            tdo_oe_n_q <= 1'h1;
        end else begin
            tdo_q <= tdo_d;
            tdo_oe_n_q <= tdo_oe_n_d;
        end
    end
    assign tdo_out = tdo_q;
    assign tdo_oe_n = tdo_oe_n_q;

    // ****************************************
    // Crossing: pad mode and cells to the core clock
    // ****************************************
    logic req_q, req_d, ack_s1_q, ack_s2_q, ack_q, ack_d, req_s1_q, req_s2_q;
    logic [scan_pkg::SNAP_W-1:0] snap_q, snap_d, snap_want;

    // Built from next values: the test clock may stop right after an update,
    // so the request has to leave on the very edge that changes mode or cells
    assign snap_want = {mode_of(ir_d), upd_d[scan_pkg::BSR_OE_BIT:scan_pkg::BSR_OUT_LSB]};

    // Snapshot is frozen until the core side acknowledges it
    always_comb begin
        req_d = req_q;
        snap_d = snap_q;
        if (req_q == ack_s2_q && snap_want != snap_q) begin
            snap_d = snap_want;
            req_d = ~req_q;
        end
    end

    always_ff @(posedge tck) begin
        ack_s1_q <= ack_q;
        ack_s2_q <= ack_s1_q;
        if (tap_rst) begin
            req_q <= 1'h0;
            snap_q <= {scan_pkg::MODE_FUNC, {(scan_pkg::IO_N + 1){1'h0}}};
        end else begin
            req_q <= req_d;
            snap_q <= snap_d;
        end
    end

    // ****************************************
    // Core-clock domain: pad multiplexer
    // ****************************************
    scan_pkg::mode_t mode_q, mode_d;
    logic [scan_pkg::IO_N:0] cells_q, cells_d;
    logic [scan_pkg::IO_N-1:0] pad_out_q, pad_out_d;
    logic pad_oe_n_q, pad_oe_n_d;

    // Take the snapshot only once its request toggle has settled
    always_comb begin
        ack_d = ack_q;
        mode_d = mode_q;
        cells_d = cells_q;
        if (req_s2_q != ack_q) begin
            ack_d = req_s2_q;
            mode_d = scan_pkg::mode_t'(snap_q[scan_pkg::SNAP_W-1:scan_pkg::IO_N+1]);
            cells_d = snap_q[scan_pkg::IO_N:0];
        end
        case (mode_q)
            scan_pkg::MODE_DRIVE: begin
                pad_out_d = cells_q[scan_pkg::IO_N-1:0];
                pad_oe_n_d = cells_q[scan_pkg::IO_N];
            end
            scan_pkg::MODE_HIGHZ: begin
                pad_out_d = func_out;
                pad_oe_n_d = 1'h1;
            end
            default: begin
                pad_out_d = func_out;
                pad_oe_n_d = func_oe_n;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        req_s1_q <= req_q;
        req_s2_q <= req_s1_q;
        if (!rst_n) begin
            ack_q <= 1'h0;
            mode_q <= scan_pkg::MODE_FUNC;
            cells_q <= '0;
            pad_out_q <= '0;
            pad_oe_n_q <= 1'h1;
        end else begin
            ack_q <= ack_d;
            mode_q <= mode_d;
            cells_q <= cells_d;
            pad_out_q <= pad_out_d;
            pad_oe_n_q <= pad_oe_n_d;
        end
    end
    assign pad_out = pad_out_q;
    assign pad_oe_n = pad_oe_n_q;

    // ****************************************
    // Checks
    // ****************************************
    sequence id_capture_s;
        ctl.state == scan_pkg::S_CAP_DR && path == scan_pkg::PATH_ID;
    endsequence
    sequence bsr_update_s;
        ctl.state == scan_pkg::S_UPD_DR && path == scan_pkg::PATH_BSR;
    endsequence

    id_revision_a: assert property (@(posedge tck) disable iff (tap_rst)
        id_capture_s |=> id_q[scan_pkg::REV_MSB:scan_pkg::REV_LSB] == REV_CODE)
        else $error("identity revision field wrong");
    id_part_a: assert property (@(posedge tck) disable iff (tap_rst)
        id_capture_s |=> id_q[scan_pkg::PART_MSB:scan_pkg::PART_LSB] == PART_CODE)
        else $error("identity part field wrong");
    id_maker_a: assert property (@(posedge tck) disable iff (tap_rst)
        id_capture_s |=> id_q[scan_pkg::MFR_MSB:scan_pkg::MFR_LSB] == MFR_CODE)
        else $error("identity maker field wrong");
    id_mark_a: assert property (@(posedge tck) disable iff (tap_rst)
        id_capture_s ##1 1'h1 |-> id_q[scan_pkg::ID_MARK_BIT] == 1'h1)
        else $error("identity marker bit not one");
    drive_path_a: assert property (@(posedge tck) disable iff (tap_rst)
        ir_q == scan_pkg::drive_cells_instr |-> path == scan_pkg::PATH_BSR
        && mode_of(ir_q) == scan_pkg::MODE_DRIVE)
        else $error("drive-cells code decoded wrongly");
    sample_capture_a: assert property (@(posedge tck) disable iff (tap_rst)
        ctl.state == scan_pkg::S_CAP_DR && ir_q == scan_pkg::sample_preload_instr
        |=> bsr_q == $past(pin_s2_q))
        else $error("sample did not capture pins");
    preload_update_a: assert property (@(posedge tck) disable iff (tap_rst)
        bsr_update_s |=> upd_q == $past(bsr_q))
        else $error("preload not taken into cells");
    id_select_a: assert property (@(posedge tck) disable iff (tap_rst)
        ir_q == scan_pkg::read_identity_instr |-> path == scan_pkg::PATH_ID)
        else $error("identity path not selected");
    highz_pads_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        mode_q == scan_pkg::MODE_HIGHZ |=> pad_oe_n == 1'h1)
        else $error("pads driven in float mode");
    clamp_drive_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        mode_q == scan_pkg::MODE_DRIVE |=> pad_out == $past(cells_q[scan_pkg::IO_N-1:0]))
        else $error("pads do not show cell values");
    ir_capture_a: assert property (@(posedge tck) disable iff (tap_rst)
        ctl.state == scan_pkg::S_CAP_IR |=> ir_shift_q == scan_pkg::capture_ir_pattern_instr)
        else $error("capture pattern not loaded");
    ir_low_bits_a: assert property (@(posedge tck) disable iff (tap_rst)
        ctl.state == scan_pkg::S_CAP_IR |=> ir_shift_q[1:0] == scan_pkg::IR_LOW_PATTERN)
        else $error("captured low bits not 01");
    bypass_one_bit_a: assert property (@(posedge tck) disable iff (tap_rst)
        ctl.state == scan_pkg::S_SHIFT_DR && ir_q == scan_pkg::bypass_instr
        |=> byp_q == $past(tdi))
        else $error("bypass path is not one bit");
    reserved_func_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        mode_q == scan_pkg::MODE_FUNC |=> pad_out == $past(func_out)
        && pad_oe_n == $past(func_oe_n))
        else $error("functional outputs disturbed");
endmodule
`default_nettype wire

/* jtag_ctl_model.sv */
// Behavioural boundary-scan test controller for the scan port
`timescale 1ns/1ps
`default_nettype none
module jtag_ctl_model (
    output logic tck, // Test clock, still between frames
    output logic tms, // Mode select
    output logic tdi, // Serial data to the device
    input wire logic tdo_out, // Serial data from the device
    input wire logic tdo_oe_n // Low while the device drives tdo
);
    // ****************************************
    // Serial pin driving
    // ****************************************
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // One 125 ns test clock cycle; tdo is taken at the rising edge
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #62.5;
        o = tdo_oe_n ? 1'bx : tdo_out; // Undriven tdo never passes for data
        tck = 1'b1;
        #62.5;
        tck = 1'b0;
    endtask
    // Five ones reach Test-Logic-Reset from anywhere, then idle
    task automatic tlr();
        logic o;
        repeat (5) step(1'b1, 1'b0, o);
        step(1'b0, 1'b1, o);
    endtask
    // Full scan from idle, LSB first, back to idle
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic o;
        dout = '0;
        step(1'b1, tdi, o);
        if (ir) step(1'b1, tdi, o);
        step(1'b0, tdi, o);
        step(1'b0, tdi, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        // Released data line shows the inverse, not the last bit
        step(1'b1, ~din[n-1], o);
        step(1'b0, ~din[n-1], o);
    endtask
endmodule
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the boundary-scan port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [31:0] ID_EXP = {4'h1, 16'h0a52, 11'h05a, 1'h1};
    logic core_clk = 1'b0;
    logic rst_n, trst_n, func_oe_n, tck, tms, tdi, tdo_out, tdo_oe_n, pad_oe_n;
    logic [scan_pkg::IO_N-1:0] func_out, pin_in, pad_out;
    logic [31:0] d;
    logic [3:0] ops [12] = '{4'h3, 4'h8, 4'hf, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'ha,
                             4'hb, 4'hc, 4'he};
    int fails = 0;
    int checked = 0;
    int cycles = 0;
    // ****************************************
    // Clock, design and controller
    // ****************************************
    always #50 core_clk = ~core_clk;
    scan_port_instruction_decode #(.WIDE_ORG(1'h0), .REV_CODE(4'h1), .PART_WIDE(16'h0a51),
        .PART_NARROW(16'h0a52), .MFR_CODE(11'h05a)) uut (
        .core_clk(core_clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
        .trst_n(trst_n), .tdo_out(tdo_out), .tdo_oe_n(tdo_oe_n), .func_out(func_out),
        .func_oe_n(func_oe_n), .pin_in(pin_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n));
    jtag_ctl_model ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo_out(tdo_out),
        .tdo_oe_n(tdo_oe_n));
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("BAD %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        if (fails == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Instruction load; the captured pattern comes out on the way
    task automatic ir(input logic [3:0] op);
        ctl.scan(1'b1, 4, {28'h0, op}, d);
        chk(32'(d[3:0]), 32'(scan_pkg::capture_ir_pattern_instr));
        chk(32'(d[1:0]), 32'(scan_pkg::IR_LOW_PATTERN));
    endtask
    // Pads after the crossing has settled, masked bits ignored
    task automatic pads(input logic [4:0] e, input logic [4:0] m);
        repeat (12) @(negedge core_clk);
        chk(32'({pad_oe_n, pad_out} & m), 32'(e));
    endtask
    // Hang guard, far above the expected run length
    always @(posedge core_clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            report_and_stop();
        end
    end
    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        rst_n = 1'b0;
        trst_n = 1'b1;
        func_out = 4'h5;
        func_oe_n = 1'b0;
        pin_in = 4'h3;
        fork
            repeat (20) @(negedge core_clk);
            ctl.tlr();
        join
        rst_n = 1'b1;
        ctl.tlr();
        ctl.scan(1'b0, 32, 32'h0, d);
        chk(d, ID_EXP);
        ir(scan_pkg::read_identity_instr);
        ctl.scan(1'b0, 32, 32'h5a5a5a5a, d);
        chk(d, ID_EXP);
        ir(scan_pkg::sample_preload_instr);
        ctl.scan(1'b0, 9, 32'h0a0, d);
        chk(32'(d[8:0]), 32'h053);
        pads(5'h05, 5'h1f);
        ir(scan_pkg::drive_cells_instr);
        pads(5'h0a, 5'h1f);
        ctl.scan(1'b0, 9, 32'h0a0, d);
        chk(32'(d[8:0]), 32'h0a3);
        // Float, hold cells, then bypass and every reserved code except 1101
        foreach (ops[i]) begin
            ir(ops[i]);
            ctl.scan(1'b0, 8, 32'hb5, d);
            chk(32'(d[7:0]), 32'({7'h35, scan_pkg::BYPASS_CAPTURE}));
            if (ops[i] == scan_pkg::highz_instr) pads(5'h10, 5'h10);
            else if (ops[i] == scan_pkg::clamp_instr) pads(5'h0a, 5'h1f);
            else pads(5'h05, 5'h1f);
        end
        // Optional test reset brings the identity instruction back
        @(negedge core_clk);
        trst_n = 1'b0;
        ctl.tlr();
        @(negedge core_clk);
        trst_n = 1'b1;
        ctl.tlr();
        ctl.scan(1'b0, 32, 32'h0, d);
        chk(d, ID_EXP);
        report_and_stop();
    end
endmodule
`default_nettype wire
